/* File: pkg/page_cmd_regs.svh */
// constants for the page read/write command engine
`ifndef PAGE_CMD_REGS_SVH
`define PAGE_CMD_REGS_SVH

`define CMD_PAGE_READ     8'h06
`define CMD_PAGE_WRITE    8'h07
`define ARG_START_PAGE    2'h0
`define ARG_PAGE_COUNT    2'h1
`define ARG_BUF_OFFSET    2'h2
`define MIN_PAGE_COUNT    8'h02
`define RES_NO_ERROR      8'h00
`define RES_BAD_COMMAND   8'h01
`define RES_BAD_ARGUMENT  8'h02
`define RES_TAG_FAIL      8'h03
`define RES_BUSY          8'hFF
`define PAGE_BYTES        4
`define BUF_BYTES         256
`define FIFO_DEPTH        8

`endif

/* File: pkg/page_cmd_pkg.sv */
// types for the page read/write command engine
`default_nettype none
package page_cmd_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CHECK,
    ST_TAG_REQ,
    ST_TAG_WAIT,
    ST_MOVE,
    ST_DONE
  } cmd_state_t;

  typedef logic [7:0] byte_t;
endpackage : page_cmd_pkg
`default_nettype wire

/* File: logic/byte_fifo.sv */
// small synchronous fifo with valid/ready on both sides
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  // pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("byte_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_ptr_r - rd_ptr_r) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr_r != rd_ptr_r;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rd_ptr_r[AW-1:0]];

  always_ff @(posedge clk)
  begin
    if (push)
      mem_r[wr_ptr_r[AW-1:0]] <= in_data;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wr_ptr_r <= '0;
    else if (push)
      wr_ptr_r <= wr_ptr_r + (AW+1)'(1);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_ptr_r <= '0;
    else if (pop)
      rd_ptr_r <= rd_ptr_r + (AW+1)'(1);
  end
endmodule : byte_fifo
`default_nettype wire

/* File: logic/page_cmd_engine.sv */
// page read / page write command engine
`include "page_cmd_regs.svh"
`default_nettype none

// Functional notes
// - read is code 06, args page/count/offset
// - write is code 07, same argument layout
// - start page is page index, not byte
// - failed read stores error, stops command
// - failed write stores error, stops command
// - read pages ascending from start page
// - read bytes contiguous from offset, no error
// - write pages ascending from start page
// - write bytes contiguous from offset, no error
module page_cmd_engine
  import page_cmd_pkg::*;
#(
  parameter int BUF_BYTES  = `BUF_BYTES,
  parameter int PAGE_BYTES = `PAGE_BYTES,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  // clock and reset
  input  wire logic       REF_CLK,
  input  wire logic       RESETN,
  // command from host
  input  wire logic       CMD_START,
  input  wire logic [7:0] CMD_CODE,
  input  wire logic [7:0] CMD_ARG0,
  input  wire logic [7:0] CMD_ARG1,
  input  wire logic [7:0] CMD_ARG2,
  output logic            CMD_BUSY,
  output logic            CMD_DONE,
  output logic [7:0]      RESULT,
  // data buffer port
  output logic            BUF_WE,
  output logic [7:0]      BUF_ADDR,
  output logic [7:0]      BUF_WDATA,
  input  wire logic [7:0] BUF_RDATA,
  // tag link: one page per request
  output logic            TAG_REQ,
  output logic            TAG_WRITE,
  output logic [7:0]      TAG_PAGE,
  input  wire logic       TAG_ACK,
  input  wire logic       TAG_ERR,
  // tag byte stream, tag to engine
  input  wire logic       TAG_RX_VALID,
  output logic            TAG_RX_READY,
  input  wire logic [7:0] TAG_RX_DATA,
  // tag byte stream, engine to tag
  output logic            TAG_TX_VALID,
  input  wire logic       TAG_TX_READY,
  output logic [7:0]      TAG_TX_DATA
);
  // refuse sizes that the 8-bit address and byte counters cannot serve
  if (BUF_BYTES > 256 || BUF_BYTES < PAGE_BYTES || PAGE_BYTES < 1 || PAGE_BYTES > 255)
  begin : g_bad_size
    $error("page_cmd_engine: unsupported buffer or page size");
  end
  if (FIFO_DEPTH < 2)
  begin : g_bad_fifo
    $error("page_cmd_engine: fifo depth below two");
  end

  // end of a transfer, offset plus size; widened so it cannot wrap for pages of up to 7 bytes
  function automatic logic [10:0] xfer_end(input logic [7:0] ofs, input logic [7:0] cnt);
    xfer_end = 11'(ofs) + 11'(cnt) * 11'(PAGE_BYTES);
  endfunction : xfer_end

  // command decode: write flag latched at start, known-code test in the check step
  function automatic logic cmd_known(input logic [7:0] code);
    cmd_known = code == `CMD_PAGE_READ || code == `CMD_PAGE_WRITE;
  endfunction : cmd_known

  function automatic logic cmd_is_write(input logic [7:0] code);
    cmd_is_write = code == `CMD_PAGE_WRITE;
  endfunction : cmd_is_write

  cmd_state_t  state_r;
  logic        is_write_r;
  logic [7:0]  page_r;
  logic [7:0]  left_r;
  logic [7:0]  addr_r;
  logic [7:0]  bcnt_r;
  logic [7:0]  result_r;
  logic        done_r;
  logic [7:0]  code_r;
  logic [7:0]  cnt_r;
  logic [7:0]  ofs_r;
  logic        rd_pend_r;

  // fifo between tag stream and buffer, direction set by the command
  logic        f_in_valid;
  logic        f_in_ready;
  logic [7:0]  f_in_data;
  logic        f_out_valid;
  logic        f_out_ready;
  logic [7:0]  f_out_data;

  byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (REF_CLK),
    .rst_n     (RESETN),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  logic page_bytes_done;
  logic rd_take;
  logic wr_fetch;
  logic page_end;

  assign page_bytes_done = bcnt_r == 8'(PAGE_BYTES);
  // page ends once its bytes passed and the fifo has fully drained
  assign page_end        = page_bytes_done && !f_out_valid && !rd_pend_r;

  // read: tag bytes flow into fifo, fifo drains into the buffer
  // write: buffer bytes (one cycle read latency) fill fifo, fifo drains to tag
  assign rd_take      = !is_write_r && state_r == ST_MOVE && TAG_RX_VALID && f_in_ready
                        && !page_bytes_done;
  assign wr_fetch     = is_write_r && state_r == ST_MOVE && !page_bytes_done
                        && f_in_ready && !rd_pend_r;
  assign TAG_RX_READY = !is_write_r && state_r == ST_MOVE && f_in_ready && !page_bytes_done;
  assign f_in_valid   = is_write_r ? rd_pend_r : rd_take;
  assign f_in_data    = is_write_r ? BUF_RDATA : TAG_RX_DATA;
  assign f_out_ready  = is_write_r ? TAG_TX_READY : 1'b1;
  assign TAG_TX_VALID = is_write_r && f_out_valid;
  assign TAG_TX_DATA  = f_out_data;
  assign BUF_WE       = !is_write_r && f_out_valid;
  assign BUF_WDATA    = f_out_data;
  assign CMD_BUSY     = state_r != ST_IDLE;
  assign CMD_DONE     = done_r;
  assign RESULT       = result_r;
  assign TAG_REQ      = state_r == ST_TAG_REQ;
  assign TAG_WRITE    = is_write_r;
  assign TAG_PAGE     = page_r;

  // command latch: arguments taken at start
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      code_r <= 8'h00;
      cnt_r  <= 8'h00;
      ofs_r  <= 8'h00;
    end
    else if (state_r == ST_IDLE && CMD_START)
    begin
      code_r <= CMD_CODE;
      cnt_r  <= CMD_ARG1;
      ofs_r  <= CMD_ARG2;
    end
  end

  // sequencing
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state_r    <= ST_IDLE;
      is_write_r <= 1'b0;
      result_r   <= `RES_NO_ERROR;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
          if (CMD_START)
          begin
            is_write_r <= cmd_is_write(CMD_CODE);
            result_r   <= `RES_BUSY;
            state_r    <= ST_CHECK;
          end
        ST_CHECK:
          // arguments vetted before any tag traffic starts
          if (!cmd_known(code_r))
          begin
            result_r <= `RES_BAD_COMMAND;
            state_r  <= ST_DONE;
          end
          else if (cnt_r < `MIN_PAGE_COUNT
                   || xfer_end(ofs_r, cnt_r) > 11'(BUF_BYTES))
          begin
            result_r <= `RES_BAD_ARGUMENT;
            state_r  <= ST_DONE;
          end
          else
          begin
            state_r <= ST_TAG_REQ;
          end
        ST_TAG_REQ:
        begin
          state_r <= ST_TAG_WAIT;
        end
        ST_TAG_WAIT:
          // an error wins over an acknowledge in the same cycle
          if (TAG_ERR)
          begin
            result_r <= `RES_TAG_FAIL;
            state_r  <= ST_DONE;
          end
          else if (TAG_ACK)
          begin
            state_r <= ST_MOVE;
          end
        ST_MOVE:
          if (page_end)
          begin
            if (left_r == 8'h01)
            begin
              result_r <= `RES_NO_ERROR;
              state_r  <= ST_DONE;
            end
            else
            begin
              state_r <= ST_TAG_REQ;
            end
          end
        ST_DONE:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // page index: zero-based page number, never a byte address
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
      page_r <= 8'h00;
    else if (state_r == ST_IDLE && CMD_START)
      page_r <= CMD_ARG0;
    else if (state_r == ST_MOVE && page_end)
      page_r <= page_r + 8'h01;
  end

  // pages still to move; reaches zero after the last page and holds until the next check
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
      left_r <= 8'h00;
    else if (state_r == ST_CHECK)
      left_r <= cnt_r;
    else if (state_r == ST_MOVE && page_end)
      left_r <= left_r - 8'h01;
  end

  // per-page byte count
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
      bcnt_r <= 8'h00;
    else if (state_r == ST_TAG_REQ)
      bcnt_r <= 8'h00;
    else if (rd_take || wr_fetch)
      bcnt_r <= bcnt_r + 8'h01;
  end

  // buffer pointer: contiguous from the offset across pages
  // wraps at 255; the bounds check keeps legal commands clear of that
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
      addr_r <= 8'h00;
    else if (state_r == ST_CHECK)
      addr_r <= ofs_r;
    else if ((BUF_WE) || wr_fetch)
      addr_r <= addr_r + 8'h01;
  end

  assign BUF_ADDR = addr_r;

  // buffer read data lands one cycle after the address
  // one fetch in flight at a time: half rate, but no skid buffer needed
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
      rd_pend_r <= 1'b0;
    else
      rd_pend_r <= wr_fetch;
  end

  // completion pulse
  always_ff @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
      done_r <= 1'b0;
    else
      done_r <= state_r == ST_DONE;
  end
endmodule : page_cmd_engine
`default_nettype wire

/* File: test/page_cmd_checker.sv */
// assertions on the page command engine ports
`default_nettype none
module page_cmd_checker (
  // clock and reset
  input wire logic       REF_CLK,
  input wire logic       RESETN,
  // command
  input wire logic       CMD_START,
  input wire logic [7:0] CMD_CODE,
  input wire logic [7:0] CMD_ARG0,
  input wire logic [7:0] CMD_ARG1,
  input wire logic [7:0] CMD_ARG2,
  input wire logic       CMD_BUSY,
  input wire logic       CMD_DONE,
  input wire logic [7:0] RESULT,
  // buffer and tag
  input wire logic       BUF_WE,
  input wire logic [7:0] BUF_ADDR,
  input wire logic       TAG_REQ,
  input wire logic [7:0] TAG_PAGE,
  input wire logic       TAG_ERR
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        st;
  logic        ok;
  logic        bad;
  logic [7:0]  ep_r;
  logic [7:0]  ea_r;
  assign st  = CMD_START && !CMD_BUSY;
  assign ok  = CMD_CODE == 8'h06 || CMD_CODE == 8'h07;
  // eleven bits so offset plus length cannot wrap
  assign bad = CMD_ARG1 < 8'h02 || {3'h0, CMD_ARG2} + {1'b0, CMD_ARG1, 2'h0} > 11'h100;
  always_ff @(posedge REF_CLK or negedge RESETN)
    if (!RESETN) ep_r <= 8'h00;
    else if (st) ep_r <= CMD_ARG0;
    else if (TAG_REQ) ep_r <= ep_r + 8'h01;
  always_ff @(posedge REF_CLK or negedge RESETN)
    if (!RESETN) ea_r <= 8'h00;
    else if (st) ea_r <= CMD_ARG2;
    else if (BUF_WE) ea_r <= ea_r + 8'h01;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  chk_arg_reject: assert property (st && ok && bad |-> ##3 CMD_DONE && RESULT == 8'h02)
    else $error("bad argument not refused");
  chk_no_tag: assert property (st && ok && bad |=> !TAG_REQ [*3])
    else $error("tag traffic on bad argument");
  chk_code_reject: assert property (st && !ok |-> ##[1:3] CMD_DONE && RESULT == 8'h01)
    else $error("bad code not refused");
  chk_busy_rise: assert property (st |=> CMD_BUSY)
    else $error("busy not raised");
  chk_page_order: assert property (TAG_REQ |-> TAG_PAGE == ep_r)
    else $error("page out of order");
  chk_buf_addr: assert property (BUF_WE |-> BUF_ADDR == ea_r)
    else $error("buffer byte misplaced");
  chk_err_stop: assert property (TAG_ERR && CMD_BUSY |=> !TAG_REQ [*4])
    else $error("pages after tag error");
  chk_err_code: assert property (TAG_ERR && CMD_BUSY |-> ##[1:4] CMD_DONE && RESULT == 8'h03)
    else $error("tag error not reported");
  chk_done_once: assert property (CMD_DONE |=> !CMD_DONE)
    else $error("done longer than a cycle");
  cover property (st && CMD_CODE == 8'h06 && !bad);
  cover property (st && CMD_CODE == 8'h07 && !bad);
  cover property (TAG_ERR && CMD_BUSY);
endmodule : page_cmd_checker
bind page_cmd_engine page_cmd_checker u_chk (.REF_CLK, .RESETN, .CMD_START, .CMD_CODE,
  .CMD_ARG0, .CMD_ARG1, .CMD_ARG2, .CMD_BUSY, .CMD_DONE, .RESULT, .BUF_WE, .BUF_ADDR,
  .TAG_REQ, .TAG_PAGE, .TAG_ERR);
`default_nettype wire

/* File: test/tag_link_model.sv */
// behavioural tag and data buffer facing the engine
`default_nettype none
module tag_link_model (
  // clock
  input wire logic       REF_CLK,
  // tag link
  input wire logic       TAG_REQ,
  input wire logic       TAG_WRITE,
  input wire logic [7:0] TAG_PAGE,
  output var logic       TAG_ACK,
  output var logic       TAG_ERR,
  output var logic       TAG_RX_VALID,
  input wire logic       TAG_RX_READY,
  output var logic [7:0] TAG_RX_DATA,
  input wire logic       TAG_TX_VALID,
  output var logic       TAG_TX_READY,
  input wire logic [7:0] TAG_TX_DATA,
  // data buffer
  input wire logic       BUF_WE,
  input wire logic [7:0] BUF_ADDR,
  input wire logic [7:0] BUF_WDATA,
  output var logic [7:0] BUF_RDATA
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] bmem [256];
  logic [7:0] wq [$];
  int         err_pg = 300;
  int         dly = 1;
  logic       tx_rdy = 1'b0;
  // ready toggles so the engine sees a stalling tag
  always @(negedge REF_CLK) tx_rdy <= ~tx_rdy;
  assign TAG_TX_READY = tx_rdy;
  always @(posedge REF_CLK)
  begin
    if (BUF_WE) bmem[BUF_ADDR] <= BUF_WDATA;
    BUF_RDATA <= bmem[BUF_ADDR];
    if (TAG_TX_VALID && TAG_TX_READY) wq.push_back(TAG_TX_DATA);
  end
  initial
  begin
    {TAG_ACK, TAG_ERR, TAG_RX_VALID, TAG_RX_DATA} = '0;
    forever
    begin
      @(posedge REF_CLK);
      if (TAG_REQ)
      begin
        repeat (dly) @(negedge REF_CLK);
        TAG_ERR = TAG_PAGE == err_pg;
        TAG_ACK = !TAG_ERR;
        @(negedge REF_CLK);
        {TAG_ACK, TAG_ERR} = '0;
        for (int k = 0; k < 4 && !TAG_WRITE && TAG_PAGE != err_pg; k++)
        begin
          TAG_RX_VALID = 1'b1;
          TAG_RX_DATA = 8'(TAG_PAGE * 4 + k) ^ 8'h3C;
          @(posedge REF_CLK);
          while (!TAG_RX_READY) @(posedge REF_CLK);
          @(negedge REF_CLK);
        end
        // released line shows no stale byte
        TAG_RX_VALID = 1'b0;
        TAG_RX_DATA = ~TAG_RX_DATA;
      end
    end
  end
endmodule : tag_link_model
`default_nettype wire

/* File: test/page_cmd_engine_tb.sv */
// self-checking bench for the page command engine
`default_nettype none
module page_cmd_engine_tb;
  import page_cmd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic       REF_CLK, RESETN, CMD_START, CMD_BUSY, CMD_DONE, BUF_WE, TAG_REQ, TAG_WRITE;
  logic       TAG_ACK, TAG_ERR, TAG_RX_VALID, TAG_RX_READY, TAG_TX_VALID, TAG_TX_READY;
  byte_t      CMD_CODE, CMD_ARG0, CMD_ARG1, CMD_ARG2, RESULT, BUF_ADDR, BUF_WDATA;
  byte_t      BUF_RDATA, TAG_PAGE, TAG_RX_DATA, TAG_TX_DATA;
  int         miscompares = 0;
  int         n_compared = 0;
  page_cmd_engine i_dut (.REF_CLK, .RESETN, .CMD_START, .CMD_CODE, .CMD_ARG0, .CMD_ARG1,
    .CMD_ARG2, .CMD_BUSY, .CMD_DONE, .RESULT, .BUF_WE, .BUF_ADDR, .BUF_WDATA, .BUF_RDATA,
    .TAG_REQ, .TAG_WRITE, .TAG_PAGE, .TAG_ACK, .TAG_ERR, .TAG_RX_VALID, .TAG_RX_READY,
    .TAG_RX_DATA, .TAG_TX_VALID, .TAG_TX_READY, .TAG_TX_DATA);
  tag_link_model m (.REF_CLK, .TAG_REQ, .TAG_WRITE, .TAG_PAGE, .TAG_ACK, .TAG_ERR,
    .TAG_RX_VALID, .TAG_RX_READY, .TAG_RX_DATA, .TAG_TX_VALID, .TAG_TX_READY,
    .TAG_TX_DATA, .BUF_WE, .BUF_ADDR, .BUF_WDATA, .BUF_RDATA);
  task automatic chk(input string nm, input byte_t e, input byte_t g);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic run(input byte_t c, a0, a1, a2, output byte_t r);
    int n;
    @(negedge REF_CLK);
    {CMD_CODE, CMD_ARG0, CMD_ARG1, CMD_ARG2} = {c, a0, a1, a2};
    CMD_START = 1'b1;
    @(negedge REF_CLK);
    CMD_START = 1'b0;
    n = 0;
    while (CMD_DONE !== 1'b1 && n < 3000)
    begin
      @(negedge REF_CLK);
      n++;
    end
    chk("done seen", 8'h01, {7'h00, CMD_DONE});
    r = RESULT;
  endtask : run
  task automatic t_read;
    byte_t r;
    run(8'h06, 8'h05, 8'h03, 8'hF4, r);
    chk("rd res", 8'h00, r);
    for (int i = 0; i < 12; i++)
      chk("rd buf", 8'(20 + i) ^ 8'h3C, m.bmem[244 + i]);
  endtask : t_read
  task automatic t_write;
    byte_t r;
    m.dly = 4;
    m.wq.delete();
    for (int i = 0; i < 8; i++)
      m.bmem[16 + i] = 8'(i * 7 + 1);
    run(8'h07, 8'h09, 8'h02, 8'h10, r);
    chk("wr res", 8'h00, r);
    chk("wr n", 8'h08, 8'(m.wq.size()));
    for (int i = 0; i < 8; i++)
      chk("wr byte", 8'(i * 7 + 1), m.wq[i]);
    m.dly = 1;
  endtask : t_write
  task automatic t_bad;
    byte_t r;
    byte_t c[4] = '{8'h06, 8'h07, 8'h06, 8'h05};
    byte_t n[4] = '{8'h01, 8'h00, 8'h02, 8'h02};
    byte_t o[4] = '{8'h00, 8'h00, 8'hFD, 8'h00};
    byte_t e[4] = '{8'h02, 8'h02, 8'h02, 8'h01};
    for (int i = 0; i < 4; i++)
    begin
      run(c[i], 8'h00, n[i], o[i], r);
      chk("bad res", e[i], r);
    end
  endtask : t_bad
  task automatic t_err;
    byte_t r;
    m.err_pg = 3;
    m.wq.delete();
    for (int i = 0; i < 2; i++)
    begin
      run(8'(8'h06 + i), 8'h02, 8'h04, 8'h00, r);
      chk("err res", 8'h03, r);
    end
    chk("err keep", 8'h08 ^ 8'h3C, m.bmem[0]);
    chk("err wr n", 8'h04, 8'(m.wq.size()));
    m.err_pg = 300;
  endtask : t_err
  task automatic results;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results
  initial
  begin
    REF_CLK = 1'b0;
    forever #4 REF_CLK = ~REF_CLK;
  end
  initial
  begin
    // generous: every command here ends in well under a thousand cycles
    repeat (20000) @(posedge REF_CLK);
    miscompares++;
    results();
  end
  initial
  begin
    {RESETN, CMD_START, CMD_CODE, CMD_ARG0, CMD_ARG1, CMD_ARG2} = '0;
    repeat (8) @(negedge REF_CLK);
    RESETN = 1'b1;
    t_read();
    t_write();
    t_bad();
    t_err();
    results();
  end
endmodule : page_cmd_engine_tb
`default_nettype wire
